/* rtl/exec_pkg.sv */
// Purpose: shared constants, types and decode for the add/and/bit/skip execution block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit register address
// Notes:   register map is word aligned on an Avalon-MM byte address
package exec_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int INSTR_W = 14;
  localparam int BUS_AW  = 12;

  // field positions inside the instruction word
  localparam int LIT_LSB   = 0;
  localparam int FILE_LSB  = 0;
  localparam int DEST_POS  = 7;
  localparam int BIT_LSB   = 7;

  // opcode encodings, by leading bits of the instruction word
  localparam logic [5:0] ENC_ADD_REGISTER = 6'h07;  // 00 0111
  localparam logic [5:0] ENC_AND_REGISTER = 6'h05;  // 00 0101
  localparam logic [3:0] ENC_CLEAR_BIT    = 4'h4;   // 01 00
  localparam logic [3:0] ENC_SET_BIT      = 4'h5;   // 01 01
  localparam logic [3:0] ENC_SKIP_LOW     = 4'h6;   // 01 10
  localparam logic [3:0] ENC_SKIP_HIGH    = 4'h7;   // 01 11
  localparam logic [4:0] ENC_ADD_LITERAL  = 5'h1F;  // 11 111x
  localparam logic [5:0] ENC_AND_LITERAL  = 6'h39;  // 11 1001

  // status bit positions
  localparam int STAT_CARRY  = 0;
  localparam int STAT_NIBBLE = 1;
  localparam int STAT_ZERO   = 2;

  // bus register offsets (byte addresses)
  localparam logic [BUS_AW-1:0] OFS_ACC    = 12'h000;
  localparam logic [BUS_AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [BUS_AW-1:0] OFS_CTRL   = 12'h008;
  localparam logic [BUS_AW-1:0] OFS_EXEC   = 12'h00C;
  localparam logic [BUS_AW-1:0] OFS_FILE   = 12'h200;  // 128 words, one per register
  localparam int CTRL_PRESCALE_TIMER = 0;

  // reset values and default special addresses
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST  = 8'h00;
  localparam logic [ADDR_W-1:0] TIMER_ADR = 7'h01;
  localparam logic [ADDR_W-1:0] PORT_ADR  = 7'h05;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD_LIT, OP_ADD_REG, OP_AND_LIT, OP_AND_REG,
    OP_CLR_BIT, OP_SET_BIT, OP_SKIP_LOW, OP_SKIP_HIGH
  } op_t;

  typedef struct packed {
    logic zero;
    logic nibble_flag;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    flags_t            flags;
    logic              upd_carry;  // carry and nibble written
    logic              upd_zero;
    logic              to_acc;
    logic              to_reg;
    logic              skip;
  } alu_out_t;

  // instruction word to operation
  function automatic op_t decode(input logic [INSTR_W-1:0] w);
    op_t o;
    o = OP_NONE;
    if (w[13:8] == ENC_ADD_REGISTER) o = OP_ADD_REG;
    else if (w[13:8] == ENC_AND_REGISTER) o = OP_AND_REG;
    else if (w[13:9] == ENC_ADD_LITERAL) o = OP_ADD_LIT;
    else if (w[13:8] == ENC_AND_LITERAL) o = OP_AND_LIT;
    else if (w[13:10] == ENC_CLEAR_BIT) o = OP_CLR_BIT;
    else if (w[13:10] == ENC_SET_BIT) o = OP_SET_BIT;
    else if (w[13:10] == ENC_SKIP_LOW) o = OP_SKIP_LOW;
    else if (w[13:10] == ENC_SKIP_HIGH) o = OP_SKIP_HIGH;
    return o;
  endfunction

endpackage

/* rtl/exec_alu.sv */
// Purpose: combinational result, flag and skip logic for one instruction
// Assumes: operands already selected by the caller
// Notes:   no state; flags are only meaningful where the update bits say so
`timescale 1ns/1ps
module exec_alu (
  input  wire exec_pkg::op_t                  op_i,
  input  wire logic [exec_pkg::DATA_W-1:0]    acc_i,
  input  wire logic [exec_pkg::DATA_W-1:0]    operand_i,
  input  wire logic [exec_pkg::DATA_W-1:0]    literal_i,
  input  wire logic [2:0]                     bit_sel_i,
  input  wire logic                           dest_i,
  output exec_pkg::alu_out_t                  out_o
);

  // 8-bit add returning {carry, nibble carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[8], n[4], s[7:0]};
  endfunction

  wire logic [9:0] add_lit  = add8(acc_i, literal_i);
  wire logic [9:0] add_reg  = add8(acc_i, operand_i);
  wire logic [7:0] bit_mask = 8'h01 << bit_sel_i;
  wire logic       bit_val  = operand_i[bit_sel_i];

  // result and side effects per operation
  always_comb begin
    out_o = '0;
    case (op_i)
      exec_pkg::OP_ADD_LIT: begin
        out_o.result = add_lit[7:0];
        out_o.flags.carry = add_lit[9];
        out_o.flags.nibble_flag = add_lit[8];
        out_o.upd_carry = 1'b1;
        out_o.upd_zero = 1'b1;
        out_o.to_acc = 1'b1;
      end
      exec_pkg::OP_ADD_REG: begin
        out_o.result = add_reg[7:0];
        out_o.flags.carry = add_reg[9];
        out_o.flags.nibble_flag = add_reg[8];
        out_o.upd_carry = 1'b1;
        out_o.upd_zero = 1'b1;
        out_o.to_acc = ~dest_i;
        out_o.to_reg = dest_i;
      end
      exec_pkg::OP_AND_LIT: begin
        out_o.result = acc_i & literal_i;
        out_o.upd_zero = 1'b1;
        out_o.to_acc = 1'b1;
      end
      exec_pkg::OP_AND_REG: begin
        out_o.result = acc_i & operand_i;
        out_o.upd_zero = 1'b1;
        out_o.to_acc = ~dest_i;
        out_o.to_reg = dest_i;
      end
      exec_pkg::OP_CLR_BIT: begin
        out_o.result = operand_i & ~bit_mask;
        out_o.to_reg = 1'b1;
      end
      exec_pkg::OP_SET_BIT: begin
        out_o.result = operand_i | bit_mask;
        out_o.to_reg = 1'b1;
      end
      exec_pkg::OP_SKIP_LOW:  out_o.skip = ~bit_val;
      exec_pkg::OP_SKIP_HIGH: out_o.skip = bit_val;
      default: out_o = '0;
    endcase
    out_o.flags.zero = (out_o.result == 8'h00);
  end

endmodule

/* rtl/add_and_bit_skip_exec.sv */
// Purpose: execution unit for add, and, bit clear/set and bit-test-skip operations
// Assumes: one instruction offered per cycle on instr_valid_i/instr_i
// Notes:   accumulator, flags and register file are also reachable over Avalon-MM
//          a taken skip voids the next slot, offered or not
//          bus writes win over an instruction on one target
//          the register file has no reset; fill it first
//          unsupported words retire as no-ops with a pulse
//          instr_i and the bus are synchronous to clock_i
//
// Behaviour
// - add literal to accumulator, result to accumulator, carry/nibble/zero updated
// - add accumulator and register, result by target select, three flags updated
// - and literal with accumulator into accumulator, only zero flag updated
// - and accumulator with register, result by target select, only zero flag
// - clear selected bit of addressed register, flags untouched
// - set selected bit of addressed register, flags untouched
// - skip if bit low: discard next instruction as no-op, two cycles
// - skip if bit high: discard next instruction as no-op, two cycles
// - reading the port register as operand uses pin levels, not latch
// - write-back to timer counter clears prescaler when assigned to timer
`timescale 1ns/1ps
module add_and_bit_skip_exec #(
  parameter logic [exec_pkg::ADDR_W-1:0] TIMER_ADR = exec_pkg::TIMER_ADR,
  parameter logic [exec_pkg::ADDR_W-1:0] PORT_ADR  = exec_pkg::PORT_ADR
) (
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          sys_rst_i,
  // instruction issue
  input  wire logic                          instr_valid_i,
  input  wire logic [exec_pkg::INSTR_W-1:0]  instr_i,
  // i/o port pins
  input  wire logic [exec_pkg::DATA_W-1:0]   port_pins_i,
  output logic      [exec_pkg::DATA_W-1:0]   port_latch_o,
  // execution results
  output logic      [exec_pkg::DATA_W-1:0]   acc_o,
  output logic                               carry_o,
  output logic                               nibble_flag_o,
  output logic                               zero_o,
  output logic                               retired_o,
  output logic                               nop_cycle_o,
  output logic                               unsupported_o,
  output logic                               prescaler_clear_o,
  // avalon-mm slave
  input  wire logic [exec_pkg::BUS_AW-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest
);

  // one register per file address
  localparam int DEPTH = 1 << exec_pkg::ADDR_W;

  // elaboration check: special addresses must be distinct
  if (TIMER_ADR == PORT_ADR) begin : g_bad_adr
    $error("timer and port addresses must differ");
  end

  // alu and flag taps assume an 8-bit datapath
  if (exec_pkg::DATA_W != 8) begin : g_bad_width
    $error("data width must be 8");
  end

  // field taps assume the 14-bit word
  if (exec_pkg::INSTR_W != 14) begin : g_bad_instr
    $error("instruction width must be 14");
  end

  // file window decode uses bits 11 to 9
  if (exec_pkg::BUS_AW != 12) begin : g_bad_bus
    $error("bus address must be 12 bits");
  end

  // run executes; discard voids one slot
  typedef enum { ST_RUN, ST_DISCARD } exec_state_t;

  // architectural state
  logic [exec_pkg::DATA_W-1:0] file_mem [DEPTH];
  logic [exec_pkg::DATA_W-1:0] acc_reg;
  exec_pkg::flags_t            flags_reg;
  logic                        prescale_timer_reg;

  // sequencing and pulse flops
  exec_state_t                 state_reg;
  exec_state_t                 state_next;
  logic                        retired_reg;
  logic                        nop_reg;
  logic                        unsup_reg;
  logic                        pclr_reg;

  // port latch and bus answer
  logic [exec_pkg::DATA_W-1:0] latch_reg;
  logic [31:0]                 rdata_reg;
  logic                        wait_reg;

  // instruction fields
  wire exec_pkg::op_t               op_dec   = exec_pkg::decode(instr_i);
  wire logic [exec_pkg::ADDR_W-1:0] file_adr = instr_i[exec_pkg::FILE_LSB +: exec_pkg::ADDR_W];
  wire logic [exec_pkg::DATA_W-1:0] literal  = instr_i[exec_pkg::LIT_LSB +: exec_pkg::DATA_W];

  // bit-op and target-select taps
  wire logic [2:0]                  bit_sel  = instr_i[exec_pkg::BIT_LSB +: 3];
  wire logic                        dest_sel = instr_i[exec_pkg::DEST_POS];

  // a discarded slot executes nothing, whatever is offered
  wire logic in_discard = (state_reg == ST_DISCARD);
  wire logic executing  = instr_valid_i && !in_discard;
  // mask the op, not the word, so fields stay put
  wire exec_pkg::op_t op_eff = executing ? op_dec : exec_pkg::OP_NONE;

  // port reads see the pins so read-modify-write keeps external levels
  // bus reads of that address still see the latch copy
  wire logic [exec_pkg::DATA_W-1:0] operand =
    (file_adr == PORT_ADR) ? port_pins_i : file_mem[file_adr];

  // op_none in a discard slot, so nothing there lands;
  // decode stays here so unsupported words are seen
  exec_pkg::alu_out_t alu;

  exec_alu u_alu (
    .op_i      (op_eff),
    .acc_i     (acc_reg),
    .operand_i (operand),
    .literal_i (literal),
    .bit_sel_i (bit_sel),
    .dest_i    (dest_sel),
    .out_o     (alu)
  );

  // write-back decode
  wire logic wr_file  = alu.to_reg;
  // port and timer writes act beyond the file
  wire logic wr_timer = wr_file && (file_adr == TIMER_ADR);
  wire logic wr_port  = wr_file && (file_adr == PORT_ADR);

  // skip sequencing
  // a skip starts only in run; discard always returns
  always_comb begin
    case (state_reg)
      ST_RUN:     state_next = alu.skip ? ST_DISCARD : ST_RUN;
      ST_DISCARD: state_next = ST_RUN;
      default:    state_next = ST_RUN;
    endcase
  end

  // bus decode
  wire logic                        bus_req  = avs_read || avs_write;
  wire logic                        bus_done = bus_req && !wait_reg;
  wire logic                        bus_file = (avs_address[11:9] == exec_pkg::OFS_FILE[11:9]);
  wire logic [exec_pkg::ADDR_W-1:0] bus_fadr = avs_address[2 +: exec_pkg::ADDR_W];
  wire logic                        bus_lo   = avs_byteenable[0];

  // write strobes: ready edge and lane 0 only
  wire logic                        bw_acc   = bus_done && avs_write && bus_lo &&
                                               (avs_address == exec_pkg::OFS_ACC);
  wire logic                        bw_stat  = bus_done && avs_write && bus_lo &&
                                               (avs_address == exec_pkg::OFS_STATUS);
  wire logic                        bw_ctrl  = bus_done && avs_write && bus_lo &&
                                               (avs_address == exec_pkg::OFS_CTRL);
  wire logic                        bw_file  = bus_done && avs_write && bus_lo && bus_file;
  wire logic [exec_pkg::DATA_W-1:0] bw_byte  = avs_writedata[exec_pkg::DATA_W-1:0];

  // read mux; unmapped offsets read zero
  // used on the capture edge, address still standing
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (bus_file) begin
      rd_mux[exec_pkg::DATA_W-1:0] = file_mem[bus_fadr];
    end else begin
      case (avs_address)
        exec_pkg::OFS_ACC:    rd_mux[exec_pkg::DATA_W-1:0] = acc_reg;
        exec_pkg::OFS_STATUS: begin
          rd_mux[exec_pkg::STAT_CARRY]  = flags_reg.carry;
          rd_mux[exec_pkg::STAT_NIBBLE] = flags_reg.nibble_flag;
          rd_mux[exec_pkg::STAT_ZERO]   = flags_reg.zero;
        end
        exec_pkg::OFS_CTRL:   rd_mux[exec_pkg::CTRL_PRESCALE_TIMER] = prescale_timer_reg;
        exec_pkg::OFS_EXEC:   rd_mux[0] = in_discard;
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // accumulator; bus write lands after the instruction so it wins a collision
  // only alu and bus writes move it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      acc_reg <= exec_pkg::ACC_RST;
    end else begin
      if (alu.to_acc) acc_reg <= alu.result;
      if (bw_acc) acc_reg <= bw_byte;
    end
  end

  // status flags, only those the operation names are touched
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_reg <= '0;
    end else begin
      if (alu.upd_carry) begin
        flags_reg.carry       <= alu.flags.carry;
        flags_reg.nibble_flag <= alu.flags.nibble_flag;
      end
      if (alu.upd_zero) flags_reg.zero <= alu.flags.zero;
      // bus write to status overrides the op
      if (bw_stat) begin
        flags_reg.carry       <= bw_byte[exec_pkg::STAT_CARRY];
        flags_reg.nibble_flag <= bw_byte[exec_pkg::STAT_NIBBLE];
        flags_reg.zero        <= bw_byte[exec_pkg::STAT_ZERO];
      end
    end
  end

  // register file; no reset on the array, it is cleared by software
  // bus write to the same address lands last
  always_ff @(posedge clock_i) begin
    if (wr_file) file_mem[file_adr] <= alu.result;
    if (bw_file) file_mem[bus_fadr] <= bw_byte;
  end

  // port output latch mirrors file writes to the port address
  // bus tested first: it wins a collision
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      latch_reg <= exec_pkg::FILE_RST;
    end else if (bw_file && bus_fadr == PORT_ADR) begin
      latch_reg <= bw_byte;
    end else if (wr_port) begin
      latch_reg <= alu.result;
    end
  end

  // prescaler assignment control
  // kept until software changes it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      prescale_timer_reg <= 1'b0;
    end else if (bw_ctrl) begin
      prescale_timer_reg <= bw_byte[exec_pkg::CTRL_PRESCALE_TIMER];
    end
  end

  // skip state
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // per-cycle pulses, one cycle each
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nop_reg     <= 1'b0;
      retired_reg <= 1'b0;
      unsup_reg   <= 1'b0;
      pclr_reg    <= 1'b0;
    end else begin
      nop_reg     <= (state_next == ST_DISCARD);
      retired_reg <= executing;
      unsup_reg   <= executing && (op_dec == exec_pkg::OP_NONE);
      pclr_reg    <= wr_timer && prescale_timer_reg;
    end
  end

  // one wait cycle per access, then a single ready cycle;
  // idle keeps waitrequest high, so no access is
  // answered before its capture edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (bus_req && wait_reg) rdata_reg <= rd_mux;
    end
  end

  // outputs straight from flops
  assign acc_o             = acc_reg;
  assign carry_o           = flags_reg.carry;
  assign nibble_flag_o     = flags_reg.nibble_flag;
  assign zero_o            = flags_reg.zero;

  // per-cycle pulses and the port latch
  assign retired_o         = retired_reg;
  assign nop_cycle_o       = nop_reg;
  assign unsupported_o     = unsup_reg;
  assign prescaler_clear_o = pclr_reg;
  assign port_latch_o      = latch_reg;

  // bus answer
  assign avs_readdata      = rdata_reg;
  assign avs_waitrequest   = wait_reg;

endmodule

/* tb/exec_chk.sv */
// Purpose: port-level checker for the add/and/bit/skip execution block
// Assumes: one clock, synchronous active-high reset
// Notes:   flags only judged when no bus write can race the instruction
`timescale 1ns/1ps
module exec_chk (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        instr_valid_i,
  input  wire logic [13:0] instr_i,
  input  wire logic [7:0]  acc_o,
  input  wire logic        carry_o,
  input  wire logic        nibble_flag_o,
  input  wire logic        zero_o,
  input  wire logic        retired_o,
  input  wire logic        nop_cycle_o,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic        avs_waitrequest
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // instruction taken this cycle with no bus write racing it
  wire       take_w  = instr_valid_i && !nop_cycle_o && !avs_write;
  wire [5:0] op_w    = instr_i[13:8];
  wire       andop_w = op_w == exec_pkg::ENC_AND_LITERAL || op_w == exec_pkg::ENC_AND_REGISTER;
  logic [8:0] sum_q;
  logic       nib_q;
  logic [7:0] and_q;
  logic       skip_q;
  logic       exec_q;

  // expected results one cycle on, kept in registers so properties stay simple
  always_ff @(posedge clock_i) begin
    sum_q  <= {1'b0, acc_o} + {1'b0, instr_i[7:0]};
    nib_q  <= ({1'b0, acc_o[3:0]} + {1'b0, instr_i[3:0]}) > 5'h0F;
    and_q  <= acc_o & instr_i[7:0];
    skip_q <= instr_valid_i && !nop_cycle_o && instr_i[13:11] == 3'b011;
    exec_q <= instr_valid_i && !nop_cycle_o;
  end

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  a_nop_cause: assert property (nop_cycle_o |-> skip_q)
    else $error("no-op cycle without a skip");
  a_nop_single: assert property (nop_cycle_o |=> !nop_cycle_o)
    else $error("no-op cycle longer than one");
  a_nop_no_retire: assert property (nop_cycle_o |=> !retired_o)
    else $error("discarded word retired");
  a_retire_cause: assert property (retired_o |-> exec_q)
    else $error("retire without an executed word");
  a_bit_flags: assert property (take_w && instr_i[13:12] == 2'b01
    |=> $stable({zero_o, nibble_flag_o, carry_o})) else $error("bit op moved a flag");
  a_and_flags: assert property (take_w && andop_w |=> $stable({nibble_flag_o, carry_o}))
    else $error("and op moved carry or nibble");
  a_add_lit: assert property (take_w && instr_i[13:9] == exec_pkg::ENC_ADD_LITERAL
    |=> {carry_o, acc_o} == sum_q && nibble_flag_o == nib_q && zero_o == (sum_q[7:0] == 8'h00))
    else $error("add literal result or flags wrong");
  a_and_lit: assert property (take_w && op_w == exec_pkg::ENC_AND_LITERAL
    |=> acc_o == and_q && zero_o == (and_q == 8'h00)) else $error("and literal wrong");

  c_skip: cover property (nop_cycle_o);
  c_bus: cover property (avs_read && !avs_waitrequest);
  c_carry: cover property ($rose(carry_o));
endmodule

bind add_and_bit_skip_exec exec_chk chk_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_o(acc_o), .carry_o(carry_o),
  .nibble_flag_o(nibble_flag_o), .zero_o(zero_o), .retired_o(retired_o),
  .nop_cycle_o(nop_cycle_o), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest));

/* tb/add_and_bit_skip_exec_tb.sv */
// Purpose: directed bench for the add/and/bit/skip execution block
// Assumes: accumulator, ctrl and register file writable over the bus
// Notes:   flags compared as {zero, nibble, carry}
`timescale 1ns/1ps
module add_and_bit_skip_exec_tb;
  localparam logic [5:0] AL = {exec_pkg::ENC_ADD_LITERAL, 1'b0};
  localparam logic [5:0] NL = exec_pkg::ENC_AND_LITERAL;
  logic        clock_i;
  logic        sys_rst_i;
  logic        instr_valid_i;
  logic [13:0] instr_i;
  logic [7:0]  port_pins_i;
  logic [7:0]  port_latch_o;
  logic [7:0]  acc_o;
  logic        carry_o;
  logic        nibble_flag_o;
  logic        zero_o;
  logic        retired_o;
  logic        nop_cycle_o;
  logic        unsupported_o;
  logic        prescaler_clear_o;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  int          fails;
  int          n_tests;

  add_and_bit_skip_exec dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .port_pins_i(port_pins_i),
    .port_latch_o(port_latch_o), .acc_o(acc_o), .carry_o(carry_o),
    .nibble_flag_o(nibble_flag_o), .zero_o(zero_o), .retired_o(retired_o),
    .nop_cycle_o(nop_cycle_o), .unsupported_o(unsupported_o),
    .prescaler_clear_o(prescaler_clear_o), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  task automatic complete_run;
    $display("mismatches %0d of %0d comparisons", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clock_i);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask

  // one instruction, then results checked after the taking edge has landed
  task automatic run(input logic [13:0] w, input logic [7:0] ea, input logic [2:0] ef);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1 chk(retired_o, 1'b1);
    chk(acc_o, ea);
    chk({zero_o, nibble_flag_o, carry_o}, ef);
  endtask

  function automatic logic [13:0] fw(input logic [5:0] e, input logic d, input logic [6:0] f);
    return {e, d, f};
  endfunction

  function automatic logic [13:0] bw(input logic [3:0] e, input int b, input logic [6:0] f);
    return {e, b[2:0], f};
  endfunction

  // skip word followed back to back by add literal 1
  task automatic pair(input logic [13:0] w, input logic taken);
    wr(exec_pkg::OFS_ACC, 8'h40);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    @(posedge clock_i);
    instr_i       <= {AL, 8'h01};
    #1 chk(nop_cycle_o, taken);
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1 chk(retired_o, !taken);
    chk(acc_o, taken ? 8'h40 : 8'h41);
  endtask

  task automatic t_reset;
    rd(exec_pkg::OFS_ACC, 8'h00);
    rd(exec_pkg::OFS_STATUS, 8'h00);
    wr(12'h100, 8'hFF);
    rd(12'h100, 8'h00);
  endtask

  task automatic t_add;
    run({AL, 8'hFF}, 8'hFF, 3'b000);
    run({AL, 8'h01}, 8'h00, 3'b111);
    run({AL, 8'h0F}, 8'h0F, 3'b000);
    run({AL, 8'h01}, 8'h10, 3'b010);
    rd(exec_pkg::OFS_STATUS, 8'h02);
    wr(12'h240, 8'hF0);
    run(fw(exec_pkg::ENC_ADD_REGISTER, 1'b1, 7'h10), 8'h10, 3'b101);
    rd(12'h240, 8'h00);
    wr(12'h240, 8'h2A);
    run(fw(exec_pkg::ENC_ADD_REGISTER, 1'b0, 7'h10), 8'h3A, 3'b000);
  endtask

  task automatic t_and;
    run({AL, 8'hCE}, 8'h08, 3'b011);
    run({NL, 8'h07}, 8'h00, 3'b111);
    wr(exec_pkg::OFS_ACC, 8'h3C);
    wr(12'h244, 8'h0F);
    run(fw(exec_pkg::ENC_AND_REGISTER, 1'b1, 7'h11), 8'h3C, 3'b011);
    rd(12'h244, 8'h0C);
    run(fw(exec_pkg::ENC_AND_REGISTER, 1'b0, 7'h11), 8'h0C, 3'b011);
  endtask

  // every bit position cleared then set, flags must not move
  task automatic t_bits;
    wr(12'h280, 8'hFF);
    for (int b = 0; b < 8; b++) begin
      run(bw(exec_pkg::ENC_CLEAR_BIT, b, 7'h20), 8'h0C, 3'b011);
      rd(12'h280, 8'(8'hFF << (b + 1)));
    end
    for (int b = 0; b < 8; b++) begin
      run(bw(exec_pkg::ENC_SET_BIT, b, 7'h20), 8'h0C, 3'b011);
      rd(12'h280, 8'((9'h002 << b) - 9'h001));
    end
  endtask

  task automatic t_skip;
    wr(12'h284, 8'h00);
    pair(bw(exec_pkg::ENC_SKIP_LOW, 7, 7'h21), 1'b1);
    pair(bw(exec_pkg::ENC_SKIP_LOW, 0, 7'h20), 1'b0);
    pair(bw(exec_pkg::ENC_SKIP_HIGH, 0, 7'h20), 1'b1);
    pair(bw(exec_pkg::ENC_SKIP_HIGH, 7, 7'h21), 1'b0);
  endtask

  // operand from the port comes from the pins, timer write-back clears prescaler
  task automatic t_port_timer;
    wr(exec_pkg::OFS_ACC, 8'h00);
    run(fw(exec_pkg::ENC_ADD_REGISTER, 1'b0, exec_pkg::PORT_ADR), 8'hA5, 3'b000);
    run(bw(exec_pkg::ENC_SET_BIT, 1, exec_pkg::PORT_ADR), 8'hA5, 3'b000);
    chk(port_latch_o, 8'hA7);
    run(bw(exec_pkg::ENC_SET_BIT, 0, exec_pkg::TIMER_ADR), 8'hA5, 3'b000);
    chk(prescaler_clear_o, 1'b0);
    wr(exec_pkg::OFS_CTRL, 8'h01);
    run(bw(exec_pkg::ENC_CLEAR_BIT, 0, exec_pkg::TIMER_ADR), 8'hA5, 3'b000);
    chk(prescaler_clear_o, 1'b1);
    run(14'h0000, 8'hA5, 3'b000);
    chk(unsupported_o, 1'b1);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // watchdog far beyond the roughly 180 cycles the tests need
  initial begin
    #100000;
    fails++;
    complete_run;
  end

  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 14'h0000;
    port_pins_i = 8'hA5;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_add;
    t_and;
    t_bits;
    t_skip;
    t_port_timer;
    complete_run;
  end
endmodule
